// ==== hw/sfsb_pkg.sv ====
// package: register map, reset values, timing and carrier types of the brake sequencer
package sfsb_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_STOP_SEL = 8'h09;
  localparam logic [7:0] IDX_REL_DLY = 8'h0a;
  localparam logic [7:0] IDX_ENG_DLY = 8'h0b;
  localparam logic [7:0] IDX_SPD_THR = 8'h0c;
  localparam logic [7:0] IDX_DIS_DLY = 8'h0d;
  localparam logic [7:0] IDX_CTRL = 8'h10;
  localparam logic [7:0] IDX_STATUS = 8'h11;
  // reset values
  localparam logic [15:0] RST_STOP_SEL = 16'h0002;
  localparam logic [15:0] RST_REL_DLY = 16'h00fa;
  localparam logic [15:0] RST_ENG_DLY = 16'h0096;
  localparam logic [15:0] RST_SPD_THR = 16'h001e;
  localparam logic [15:0] RST_DIS_DLY = 16'h01f4;
  localparam logic [15:0] RST_CTRL = 16'h0001;
  // ranges
  localparam logic [15:0] MAX_STOP_SEL = 16'h0002;
  localparam logic [15:0] MIN_REL_DLY = 16'h0000;
  localparam logic [15:0] MAX_REL_DLY = 16'h01f4;
  localparam logic [15:0] MIN_ENG_DLY = 16'h0032;
  localparam logic [15:0] MAX_ENG_DLY = 16'h03e8;
  localparam logic [15:0] MIN_SPD_THR = 16'h0014;
  localparam logic [15:0] MAX_SPD_THR = 16'h0bb8;
  localparam logic [15:0] MIN_DIS_DLY = 16'h0001;
  localparam logic [15:0] MAX_DIS_DLY = 16'h03e8;
  // control field position
  localparam int CTRL_BRAKE_EN_BIT = 0;
  // time base: 1 ms tick at 25 MHz
  localparam int TICK_MS = 1;
  localparam int CLK_HZ = 25000000;
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
  // stop action codes
  typedef enum logic [1:0] {
    SFSB_STOP_COAST = 2'h0,
    SFSB_STOP_DB_OFF = 2'h1,
    SFSB_STOP_DB_HOLD = 2'h2
  } sfsb_stop_e;
  // motion reference carried as one bundle
  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [31:0] value;
  } sfsb_ref_s;
  // drive power stage requests
  typedef struct packed {
    logic energize;
    logic dyn_brake;
    logic accept_cmd;
  } sfsb_power_s;
endpackage : sfsb_pkg

// ==== hw/sfsb_ms_timer.sv ====
// module: millisecond down-counter loaded with a delay in ms
`timescale 1ns/100ps
module sfsb_ms_timer #(
  parameter int TICK_CYCLES = sfsb_pkg::TICK_CYCLES
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic start, // load the delay and run
  input wire logic stop, // abandon the count
  input wire logic [15:0] delay_ms, // delay in ms
  output logic done // one-cycle pulse at expiry
);
  logic [24:0] pre_reg;
  logic [15:0] ms_reg;
  logic run_reg;
  // a zero delay expires on the cycle after start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg <= '0;
      ms_reg <= '0;
      run_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        pre_reg <= '0;
        ms_reg <= delay_ms;
        run_reg <= 1'b1;
      end else if (stop) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        if (ms_reg == 16'h0000) begin
          run_reg <= 1'b0;
          done <= 1'b1;
        end else if (pre_reg == 25'(TICK_CYCLES - 1)) begin
          pre_reg <= '0;
          ms_reg <= ms_reg - 16'h0001;
        end else begin
          pre_reg <= pre_reg + 25'h0000001;
        end
      end
    end
  end
endmodule : sfsb_ms_timer

// ==== hw/sfsb_sequencer.sv ====
// module: class 1 fault stop selection and holding brake sequencing with AHB-Lite registers
`timescale 1ns/100ps
module sfsb_sequencer #(
  parameter int TICK_CYCLES = sfsb_pkg::TICK_CYCLES
) (
  input wire logic hclk, // bus and block clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic servo_enable_pin, // servo enable request, asynchronous
  input wire logic class1_fault_pin, // severe fault, asynchronous
  input wire logic [15:0] motor_speed, // speed magnitude, same clock
  input wire sfsb_pkg::sfsb_ref_s ref_in, // incoming motion reference
  output sfsb_pkg::sfsb_ref_s ref_out, // reference passed on
  output logic holding_brake_output, // high releases the brake
  output sfsb_pkg::sfsb_power_s power // power stage requests
);
  typedef enum logic [2:0] {
    ST_OFF, ST_RELEASE, ST_RUN, ST_ENG_STILL, ST_ENG_ROT, ST_FAULT
  } sfsb_state_e;
  // ===================================================================
  // register file
  logic [15:0] stop_sel_reg, rel_dly_reg, eng_dly_reg, spd_thr_reg, dis_dly_reg, ctrl_reg;
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  sfsb_state_e state_reg;
  logic [1:0] en_sync_reg, flt_sync_reg;
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    word_idx = a[9:2];
  endfunction : word_idx
  wire addr_ok = hsel && hready && htrans[1];
  // capture the address phase; write data lands in the following cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_idx_reg <= word_idx(haddr);
    end
  end
  // out-of-range writes are clamped so the timers never see an illegal delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_sel_reg <= sfsb_pkg::RST_STOP_SEL;
      rel_dly_reg <= sfsb_pkg::RST_REL_DLY;
      eng_dly_reg <= sfsb_pkg::RST_ENG_DLY;
      spd_thr_reg <= sfsb_pkg::RST_SPD_THR;
      dis_dly_reg <= sfsb_pkg::RST_DIS_DLY;
      ctrl_reg <= sfsb_pkg::RST_CTRL;
    end else if (wr_pend_reg) begin
      case (wr_idx_reg)
        sfsb_pkg::IDX_STOP_SEL: stop_sel_reg <= (hwdata[15:0] > sfsb_pkg::MAX_STOP_SEL) ?
                                                sfsb_pkg::MAX_STOP_SEL : hwdata[15:0];
        sfsb_pkg::IDX_REL_DLY: rel_dly_reg <= clamp(hwdata[15:0], sfsb_pkg::MIN_REL_DLY,
                                                    sfsb_pkg::MAX_REL_DLY);
        sfsb_pkg::IDX_ENG_DLY: eng_dly_reg <= clamp(hwdata[15:0], sfsb_pkg::MIN_ENG_DLY,
                                                    sfsb_pkg::MAX_ENG_DLY);
        sfsb_pkg::IDX_SPD_THR: spd_thr_reg <= clamp(hwdata[15:0], sfsb_pkg::MIN_SPD_THR,
                                                    sfsb_pkg::MAX_SPD_THR);
        sfsb_pkg::IDX_DIS_DLY: dis_dly_reg <= clamp(hwdata[15:0], sfsb_pkg::MIN_DIS_DLY,
                                                    sfsb_pkg::MAX_DIS_DLY);
        sfsb_pkg::IDX_CTRL: ctrl_reg <= {15'h0000, hwdata[sfsb_pkg::CTRL_BRAKE_EN_BIT]};
        default: ;
      endcase
    end
  end
  // read data registered in the address phase; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      case (word_idx(haddr))
        sfsb_pkg::IDX_STOP_SEL: hrdata <= {16'h0000, stop_sel_reg};
        sfsb_pkg::IDX_REL_DLY: hrdata <= {16'h0000, rel_dly_reg};
        sfsb_pkg::IDX_ENG_DLY: hrdata <= {16'h0000, eng_dly_reg};
        sfsb_pkg::IDX_SPD_THR: hrdata <= {16'h0000, spd_thr_reg};
        sfsb_pkg::IDX_DIS_DLY: hrdata <= {16'h0000, dis_dly_reg};
        sfsb_pkg::IDX_CTRL: hrdata <= {16'h0000, ctrl_reg};
        sfsb_pkg::IDX_STATUS: hrdata <= {24'h000000, holding_brake_output, power.energize,
                                         power.dyn_brake, power.accept_cmd, 1'b0, state_reg};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end
  // zero wait states, okay only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  // ===================================================================
  // pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_sync_reg <= 2'b00;
      flt_sync_reg <= 2'b00;
    end else begin
      en_sync_reg <= {en_sync_reg[0], servo_enable_pin};
      flt_sync_reg <= {flt_sync_reg[0], class1_fault_pin};
    end
  end
  wire enable_s = en_sync_reg[1];
  wire fault_s = flt_sync_reg[1];
  wire brake_en = ctrl_reg[sfsb_pkg::CTRL_BRAKE_EN_BIT];
  wire below_thr = motor_speed < spd_thr_reg;
  // ===================================================================
  // sequencer
  sfsb_state_e state_next;
  logic tmr_start, tmr_done;
  logic [15:0] tmr_dly;
  sfsb_pkg::sfsb_stop_e stop_act;
  // brake function overrides the fault stop choice
  always_comb begin
    if (brake_en) begin
      stop_act = sfsb_pkg::SFSB_STOP_DB_HOLD;
    end else begin
      stop_act = sfsb_pkg::sfsb_stop_e'(stop_sel_reg[1:0]);
    end
  end
  always_comb begin
    state_next = state_reg;
    tmr_start = 1'b0;
    tmr_dly = rel_dly_reg;
    case (state_reg)
      ST_OFF: if (enable_s && !fault_s) begin
        state_next = ST_RELEASE;
        tmr_start = 1'b1;
        tmr_dly = rel_dly_reg;
      end
      ST_RELEASE: if (!enable_s) begin
        state_next = ST_OFF;
      end else if (tmr_done) begin
        state_next = ST_RUN;
      end
      ST_RUN: if (!enable_s) begin
        tmr_start = 1'b1;
        if (below_thr) begin
          state_next = ST_ENG_STILL;
          tmr_dly = eng_dly_reg;
        end else begin
          state_next = ST_ENG_ROT;
          tmr_dly = dis_dly_reg;
        end
      end
      ST_ENG_STILL: if (tmr_done) begin
        state_next = ST_OFF;
      end
      ST_ENG_ROT: if (tmr_done || below_thr) begin
        state_next = ST_OFF;
      end
      ST_FAULT: if (!fault_s && !enable_s) begin
        state_next = ST_OFF;
      end
      default: state_next = ST_OFF;
    endcase
    if (fault_s && state_reg != ST_FAULT) begin
      state_next = ST_FAULT;
      tmr_start = 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end
  sfsb_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(tmr_start),
    .stop(state_next == ST_OFF || state_next == ST_FAULT),
    .delay_ms(tmr_dly),
    .done(tmr_done)
  );
  // ===================================================================
  // outputs, all registered from the next state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      holding_brake_output <= 1'b0;
      power <= '0;
      ref_out <= '0;
    end else begin
      // a rotating stop keeps the brake released until speed or delay ends it
      holding_brake_output <= state_next inside {ST_RELEASE, ST_RUN, ST_ENG_ROT};
      power.energize <= state_next inside {ST_RELEASE, ST_RUN, ST_ENG_STILL, ST_ENG_ROT};
      power.accept_cmd <= state_next == ST_RUN;
      // fault stop: coast never brakes; mode 1 releases braking once the motor is slow
      power.dyn_brake <= state_next == ST_FAULT &&
                         (stop_act == sfsb_pkg::SFSB_STOP_DB_HOLD ||
                          (stop_act == sfsb_pkg::SFSB_STOP_DB_OFF && !below_thr));
      ref_out <= ref_in;
      ref_out.valid <= ref_in.valid && state_next == ST_RUN;
    end
  end
endmodule : sfsb_sequencer

// ==== testbench/sfsb_sequencer_asserts.sv ====
// checker: port-level properties of the brake sequencer
`timescale 1ns/100ps
// ==========
// assertions
module sfsb_sequencer_asserts #(
  parameter int TICK_CYCLES = sfsb_pkg::TICK_CYCLES
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // write
  input wire logic [2:0] hsize, // size
  input wire logic [31:0] hwdata, // wdata
  input wire logic hready, // ready in
  input wire logic [31:0] hrdata, // rdata
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic servo_enable_pin, // enable
  input wire logic class1_fault_pin, // fault
  input wire logic [15:0] motor_speed, // speed
  input wire sfsb_pkg::sfsb_ref_s ref_in, // ref in
  input wire sfsb_pkg::sfsb_ref_s ref_out, // ref out
  input wire logic holding_brake_output, // brake
  input wire sfsb_pkg::sfsb_power_s power // stage
);
  // longest time the brake may stay released once enable is gone: slowest rotating stop
  localparam int ROT_LIMIT = TICK_CYCLES * int'(sfsb_pkg::MAX_DIS_DLY) + 8;
  logic [31:0] rot_cnt_reg;
  // count cycles of released brake with enable removed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rot_cnt_reg <= 32'h0;
    end else if (holding_brake_output && !servo_enable_pin) begin
      rot_cnt_reg <= rot_cnt_reg + 32'h1;
    end else begin
      rot_cnt_reg <= 32'h0;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // bus never stalls and never errors
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0) else $error("upper bits set");
  // a passed reference is the one offered a cycle earlier, and only when accepting
  a_ref_copy: assert property (ref_out.valid |-> ref_out.value == $past(ref_in.value))
    else $error("reference altered");
  a_ref_gated: assert property (ref_out.valid |-> power.accept_cmd && holding_brake_output)
    else $error("reference passed while not accepting");
  a_accept_brake: assert property ($rose(power.accept_cmd) |-> $past(holding_brake_output))
    else $error("accepting before brake release");
  // motor is never de-energized while the brake is still released
  a_brake_first: assert property ($fell(power.energize) |-> !holding_brake_output)
    else $error("de-energized with brake released");
  a_fault_stop: assert property (class1_fault_pin [*6] |-> !power.accept_cmd
    && !holding_brake_output) else $error("fault did not stop drive");
  a_disable_off: assert property (rot_cnt_reg <= 32'(ROT_LIMIT))
    else $error("brake still released after disable");
  cover property ($rose(power.accept_cmd));
  cover property ($fell(power.energize));
  cover property ($rose(power.dyn_brake));
endmodule : sfsb_sequencer_asserts

bind sfsb_sequencer sfsb_sequencer_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .servo_enable_pin, .class1_fault_pin, .motor_speed, .ref_in, .ref_out,
  .holding_brake_output, .power);

// ==== testbench/sfsb_brake_model.sv ====
// partner: motion reference source and shaft speed feedback
`timescale 1ns/100ps
// =====
// model
module sfsb_brake_model (
  input wire logic hclk, // clock
  input wire logic [15:0] spd_set, // speed asked by bench
  output logic [15:0] motor_speed, // speed fed back
  output sfsb_pkg::sfsb_ref_s ref_in // references
);
  logic [31:0] cnt_reg = 32'h0;
  always_ff @(posedge hclk) begin
    cnt_reg <= cnt_reg + 32'h1;
    motor_speed <= spd_set;
  end
  // valid every other cycle; value changes every cycle so stale data never looks right
  assign ref_in = {cnt_reg[0], 2'h1, cnt_reg ^ 32'ha5a5a5a5};
endmodule : sfsb_brake_model

// ==== testbench/sfsb_sequencer_tb.sv ====
// bench: register and brake sequencing tests of the sequencer
`timescale 1ns/100ps
// =====
// bench
module sfsb_sequencer_tb;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, servo_enable_pin, class1_fault_pin, hreadyout, hresp;
  logic holding_brake_output;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [15:0] spd, motor_speed;
  logic [7:0] a;
  sfsb_pkg::sfsb_ref_s ref_in, ref_out;
  sfsb_pkg::sfsb_power_s power;
  int miscompares = 0, samples_checked = 0, cyc = 0, n, j;
  logic [15:0] rv [6] = '{sfsb_pkg::RST_STOP_SEL, sfsb_pkg::RST_REL_DLY, sfsb_pkg::RST_ENG_DLY,
    sfsb_pkg::RST_SPD_THR, sfsb_pkg::RST_DIS_DLY, sfsb_pkg::RST_CTRL};
  logic [15:0] mx [5] = '{sfsb_pkg::MAX_STOP_SEL, sfsb_pkg::MAX_REL_DLY, sfsb_pkg::MAX_ENG_DLY,
    sfsb_pkg::MAX_SPD_THR, sfsb_pkg::MAX_DIS_DLY};
  logic [15:0] mn [5] = '{16'h0, sfsb_pkg::MIN_REL_DLY, sfsb_pkg::MIN_ENG_DLY,
    sfsb_pkg::MIN_SPD_THR, sfsb_pkg::MIN_DIS_DLY};
  // short tick keeps millisecond delays to a few cycles each
  sfsb_sequencer #(.TICK_CYCLES(4)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .servo_enable_pin,
    .class1_fault_pin, .motor_speed, .ref_in, .ref_out, .holding_brake_output, .power);
  sfsb_brake_model model (.hclk, .spd_set(spd), .motor_speed, .ref_in);
  initial begin
    forever #20 hclk = ~hclk;
  end
  // one single-word transfer; rd holds read data
  task ahb(input logic w, input logic [7:0] x, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, x, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  function logic pick(int s);
    return s == 0 ? power.accept_cmd : s == 1 ? holding_brake_output : power.energize;
  endfunction : pick
  // count settled cycles until an output reaches a level; j counts passed references
  task till(input int s, input logic v);
    n = 0;
    while (pick(s) !== v && n < 3000) begin
      @(posedge hclk);
      #1;
      n++;
      if (ref_out.valid === 1'b1) j++;
    end
  endtask : till
  task give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, servo_enable_pin, class1_fault_pin} = 5'h0;
    {haddr, hwdata, htrans, spd} = 82'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      a = i < 5 ? sfsb_pkg::IDX_STOP_SEL + 8'(i) : sfsb_pkg::IDX_CTRL;
      ahb(1'b0, a, 32'h0);
      chk(rd, {16'h0, rv[i]});
    end
    ahb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    // out of range values clamp to the ends of each range
    for (int i = 0; i < 5; i++) begin
      a = sfsb_pkg::IDX_STOP_SEL + 8'(i);
      ahb(1'b1, a, 32'hffff);
      ahb(1'b0, a, 32'h0);
      chk(rd, {16'h0, mx[i]});
      ahb(1'b1, a, 32'h0);
      ahb(1'b0, a, 32'h0);
      chk(rd, {16'h0, mn[i]});
    end
    ahb(1'b1, sfsb_pkg::IDX_REL_DLY, 32'h3);
    ahb(1'b1, sfsb_pkg::IDX_ENG_DLY, 32'h32);
    ahb(1'b1, sfsb_pkg::IDX_SPD_THR, 32'h1e);
    ahb(1'b1, sfsb_pkg::IDX_DIS_DLY, 32'h14);
    servo_enable_pin <= 1'b1;
    till(1, 1'b1);
    j = 0;
    till(0, 1'b1);
    chk(32'(n >= 11 && n <= 17), 32'h1);
    chk(32'(j <= 1), 32'h1);
    j = 0;
    repeat (4) begin
      @(posedge hclk);
      if (ref_out.valid === 1'b1) j++;
    end
    chk(32'(j > 0), 32'h1);
    // status while running: brake released, energized, accepting, state code 2
    ahb(1'b0, sfsb_pkg::IDX_STATUS, 32'h0);
    chk(rd, 32'h000000d2);
    // standstill stop: motor held energized for the engage delay
    servo_enable_pin <= 1'b0;
    till(1, 1'b0);
    till(2, 1'b0);
    chk(32'(n >= 198 && n <= 206), 32'h1);
    spd <= 16'd100;
    servo_enable_pin <= 1'b1;
    till(0, 1'b1);
    servo_enable_pin <= 1'b0;
    // rotating stop: brake stays released for the disable delay, then all drops
    till(1, 1'b0);
    chk(32'(n >= 80 && n <= 88), 32'h1);
    chk(32'(power.energize), 32'h0);
    servo_enable_pin <= 1'b1;
    till(0, 1'b1);
    servo_enable_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    spd <= 16'd30;
    repeat (20) @(posedge hclk);
    chk(32'(power.energize), 32'h1);
    chk(32'(holding_brake_output), 32'h1);
    spd <= 16'd29;
    till(2, 1'b0);
    chk(32'(n <= 8), 32'h1);
    // fault stop for each setting, the last with the brake function forcing mode 2
    for (int k = 0; k < 4; k++) begin
      ahb(1'b1, sfsb_pkg::IDX_CTRL, 32'(k == 3));
      ahb(1'b1, sfsb_pkg::IDX_STOP_SEL, 32'(k % 3));
      spd <= 16'd100;
      servo_enable_pin <= 1'b1;
      till(0, 1'b1);
      class1_fault_pin <= 1'b1;
      repeat (8) @(posedge hclk);
      chk(32'(power.dyn_brake), 32'(k != 0));
      spd <= 16'd20;
      repeat (8) @(posedge hclk);
      chk(32'(power.dyn_brake), 32'(k >= 2));
      {class1_fault_pin, servo_enable_pin} <= 2'h0;
      repeat (8) @(posedge hclk);
    end
    give_verdict();
  end
endmodule : sfsb_sequencer_tb
